// file: inc/msp_pkg.sv
/*
 Constants, state encodings and carrier types of the MIDI serial port.
 Assumes a 200 MHz single clock and byte-wide I/O port strobes on that clock.
*/
package msp_pkg;

    localparam logic [9:0] MSP_DATA_OFS   = 10'h330;
    localparam logic [9:0] MSP_CTRL_OFS   = 10'h331;
    localparam logic [9:0] MSP_ISTAT_OFS  = 10'h332;
    localparam logic [9:0] MSP_LSTAT_OFS  = 10'h335;

    localparam int         MSP_CTRL_RXIE_BIT = 0;
    localparam int         MSP_CTRL_TXIE_BIT = 1;
    localparam int         MSP_CTRL_THRU_BIT = 4;
    localparam logic [7:0] MSP_CTRL_MASK     = 8'h13;
    localparam logic [7:0] MSP_CTRL_RESET    = 8'h00;

    localparam int         MSP_IST_PEND_BIT  = 0;
    localparam int         MSP_LST_AVAIL_BIT = 0;
    localparam int         MSP_LST_OVR_BIT   = 1;
    localparam int         MSP_LST_FE_BIT    = 3;
    localparam int         MSP_LST_TXE_BIT   = 5;
    localparam logic [7:0] MSP_UNMAPPED_READ = 8'h00;

    localparam int         MSP_CLK_HZ        = 200_000_000;
    localparam int         MSP_BIT_RATE      = 31_250;
    localparam int         MSP_BIT_CYCLES    = MSP_CLK_HZ / MSP_BIT_RATE;

    typedef enum logic [1:0] {MSP_RX_IDLE, MSP_RX_START, MSP_RX_DATA, MSP_RX_STOP} msp_rx_st_t;
    typedef enum logic       {MSP_TX_IDLE, MSP_TX_SEND} msp_tx_st_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } msp_io_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } msp_io_rsp_t;

endpackage

// file: logic/msp_buf2.sv
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes both sides sit on the same clock.
*/
`timescale 1ns/100ps
module msp_buf2 import msp_pkg::*; #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wptr;
        logic                  rptr;
        logic [1:0]            count;
    } msp_buf_state_t;

    msp_buf_state_t st_reg;
    msp_buf_state_t st_next;
    logic           push;
    logic           pop;

    assign in_ready  = (st_reg.count != 2'd2);
    assign out_valid = (st_reg.count != 2'd0);
    assign out_data  = st_reg.mem[st_reg.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wptr] = in_data;
            st_next.wptr             = ~st_reg.wptr;
        end
        if (pop) begin
            st_next.rptr = ~st_reg.rptr;
        end
        // Simultaneous push and pop leaves the count alone
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // msp_buf2

// file: logic/msp_port.sv
/*
 MIDI serial port: byte-wide I/O ports, 8N1 receiver and transmitter, out/thru routing.
 Assumes io_req strobes are one-cycle pulses on clk and the MIDI input pin is asynchronous.
*/
`timescale 1ns/100ps
module msp_port import msp_pkg::*; #(
    parameter int BIT_CYCLES = MSP_BIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire msp_io_req_t io_req,
    output msp_io_rsp_t      io_rsp,
    output logic             irq7,
    input  wire logic        midi_in,
    output logic             midi_out
);

    localparam logic [15:0] BIT_CNT  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_CNT = 16'(BIT_CYCLES / 2 - 1);

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  rx_data;
        logic        avail;
        logic        framing;
        logic        overrun;
        msp_io_rsp_t rsp;
        logic        sync1;
        logic        sync2;
        msp_rx_st_t  rx_st;
        logic [15:0] rx_cnt;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        msp_tx_st_t  tx_st;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic        out_pin;
        logic        irq;
    } msp_state_t;

    msp_state_t st_reg;
    msp_state_t st_next;
    logic       buf_in_valid;
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic       buf_out_ready;
    logic [7:0] buf_out_data;
    logic       rd_data;
    logic       rd_lstat;
    logic       pend;

    function automatic logic hit(input msp_io_req_t r, input logic [9:0] ofs);
        return r.addr == ofs;
    endfunction

    function automatic logic [15:0] cnt_dec(input logic [15:0] c);
        return c - 16'd1;
    endfunction

    function automatic logic cnt_zero(input logic [15:0] c);
        return c == 16'd0;
    endfunction

    function automatic logic [7:0] istat_word(input logic p);
        logic [7:0] w;
        w                   = '0;
        w[MSP_IST_PEND_BIT] = p;
        return w;
    endfunction

    // Reserved bits read as zero so software can test whole bytes
    function automatic logic [7:0] lstat_word(input logic txe, input logic fe, input logic ovr, input logic av);
        logic [7:0] w;
        w                    = '0;
        w[MSP_LST_TXE_BIT]   = txe;
        w[MSP_LST_FE_BIT]    = fe;
        w[MSP_LST_OVR_BIT]   = ovr;
        w[MSP_LST_AVAIL_BIT] = av;
        return w;
    endfunction

    // Writes to a full buffer are dropped; software is expected to poll transmit empty first
    assign buf_in_valid  = io_req.wr && hit(io_req, MSP_DATA_OFS);
    assign buf_out_ready = (st_reg.tx_st == MSP_TX_IDLE);
    assign rd_data       = io_req.rd && hit(io_req, MSP_DATA_OFS);
    assign rd_lstat      = io_req.rd && hit(io_req, MSP_LSTAT_OFS);
    assign pend = (st_reg.ctrl[MSP_CTRL_RXIE_BIT] && st_reg.avail)
               || (st_reg.ctrl[MSP_CTRL_TXIE_BIT] && buf_in_ready);

    msp_buf2 #(
        .WIDTH (8)
    ) u_txbuf (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (io_req.wdata),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = midi_in;
        st_next.sync2 = st_reg.sync1;

        // Status flags clear on read; a same-cycle hardware set below overrides the clear
        if (rd_data) begin
            st_next.avail = 1'b0;
        end
        if (rd_lstat) begin
            st_next.framing = 1'b0;
            st_next.overrun = 1'b0;
        end

        unique case (st_reg.rx_st)
            MSP_RX_IDLE: begin
                if (!st_reg.sync2) begin
                    st_next.rx_st  = MSP_RX_START;
                    st_next.rx_cnt = HALF_CNT;
                end
            end
            MSP_RX_START: begin
                st_next.rx_cnt = cnt_dec(st_reg.rx_cnt);
                if (cnt_zero(st_reg.rx_cnt)) begin
                    // A glitch shorter than half a bit is not a start bit
                    st_next.rx_st  = st_reg.sync2 ? MSP_RX_IDLE : MSP_RX_DATA;
                    st_next.rx_cnt = BIT_CNT;
                    st_next.rx_bit = 3'd0;
                end
            end
            MSP_RX_DATA: begin
                st_next.rx_cnt = cnt_dec(st_reg.rx_cnt);
                if (cnt_zero(st_reg.rx_cnt)) begin
                    st_next.rx_sh  = {st_reg.sync2, st_reg.rx_sh[7:1]};
                    st_next.rx_cnt = BIT_CNT;
                    st_next.rx_bit = st_reg.rx_bit + 3'd1;
                    if (st_reg.rx_bit == 3'd7) begin
                        st_next.rx_st = MSP_RX_STOP;
                    end
                end
            end
            MSP_RX_STOP: begin
                st_next.rx_cnt = cnt_dec(st_reg.rx_cnt);
                if (cnt_zero(st_reg.rx_cnt)) begin
                    st_next.rx_st   = MSP_RX_IDLE;
                    st_next.rx_data = st_reg.rx_sh;
                    st_next.avail   = 1'b1;
                    if (st_reg.avail && !rd_data) begin
                        st_next.overrun = 1'b1;
                    end
                    if (!st_reg.sync2) begin
                        st_next.framing = 1'b1;
                    end
                end
            end
        endcase

        unique case (st_reg.tx_st)
            MSP_TX_IDLE: begin
                st_next.tx_sh = '1;
                if (buf_out_valid) begin
                    st_next.tx_st  = MSP_TX_SEND;
                    st_next.tx_sh  = {1'b1, buf_out_data, 1'b0};
                    st_next.tx_cnt = BIT_CNT;
                    st_next.tx_bit = 4'd0;
                end
            end
            MSP_TX_SEND: begin
                st_next.tx_cnt = cnt_dec(st_reg.tx_cnt);
                if (cnt_zero(st_reg.tx_cnt)) begin
                    st_next.tx_cnt = BIT_CNT;
                    st_next.tx_sh  = {1'b1, st_reg.tx_sh[9:1]};
                    st_next.tx_bit = st_reg.tx_bit + 4'd1;
                    if (st_reg.tx_bit == 4'd9) begin
                        st_next.tx_st = MSP_TX_IDLE;
                    end
                end
            end
        endcase

        // Thru echoes the synchronised input, so it lags the pin by the two sync stages and the output flop
        st_next.out_pin = st_reg.ctrl[MSP_CTRL_THRU_BIT] ? st_reg.sync2 : st_reg.tx_sh[0];

        if (io_req.wr && hit(io_req, MSP_CTRL_OFS)) begin
            st_next.ctrl = io_req.wdata & MSP_CTRL_MASK;
        end

        st_next.irq       = pend;
        st_next.rsp.valid = io_req.rd;
        st_next.rsp.data  = MSP_UNMAPPED_READ;
        if (io_req.rd) begin
            unique case (io_req.addr)
                MSP_DATA_OFS:  st_next.rsp.data = st_reg.rx_data;
                MSP_CTRL_OFS:  st_next.rsp.data = st_reg.ctrl;
                MSP_ISTAT_OFS: st_next.rsp.data = istat_word(pend);
                MSP_LSTAT_OFS: st_next.rsp.data = lstat_word(buf_in_ready, st_reg.framing,
                                                             st_reg.overrun, st_reg.avail);
                default: st_next.rsp.data = MSP_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg         <= '0;
            st_reg.ctrl    <= MSP_CTRL_RESET;
            st_reg.sync1   <= 1'b1;
            st_reg.sync2   <= 1'b1;
            st_reg.tx_sh   <= '1;
            st_reg.out_pin <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign io_rsp   = st_reg.rsp;
    assign irq7     = st_reg.irq;
    assign midi_out = st_reg.out_pin;

endmodule // msp_port

// file: dv/msp_chk.sv
/* Assertions on the MIDI port pins.
 Assumes a bind to msp_port on one clock. */
`timescale 1ns/100ps
module msp_chk import msp_pkg::*; (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire msp_io_req_t io_req,
    input wire msp_io_rsp_t io_rsp,
    input wire logic        irq7,
    input wire logic        midi_in,
    input wire logic        midi_out
);
    logic rd_ctl, rd_ist, rd_lst, wr_ctl;
    assign rd_ctl = io_req.rd && io_req.addr == MSP_CTRL_OFS;
    assign rd_ist = io_req.rd && io_req.addr == MSP_ISTAT_OFS;
    assign rd_lst = io_req.rd && io_req.addr == MSP_LSTAT_OFS;
    assign wr_ctl = io_req.wr && io_req.addr == MSP_CTRL_OFS;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic thru_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            thru_q <= 1'b0;
        end else if (wr_ctl) begin
            thru_q <= io_req.wdata[MSP_CTRL_THRU_BIT];
        end
    end
    // Thru echo passes two sync stages and the output flop
    property p_thru_echo; $past(thru_q) |-> midi_out == $past(midi_in, 3); endproperty
    a_thru_echo: assert property (p_thru_echo) else $error("thru output differs from input");
    property p_rd_ans; io_req.rd |=> io_rsp.valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_ans; !io_req.rd |=> !io_rsp.valid; endproperty
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    property p_ctl_rsv; rd_ctl |=> (io_rsp.data & ~MSP_CTRL_MASK) == 8'h00; endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bit set");
    property p_irq_line; rd_ist |=> io_rsp.data[0] == irq7; endproperty
    a_irq_line: assert property (p_irq_line) else $error("irq7 differs from pending");
    property p_ist_rsv; rd_ist |=> io_rsp.data[7:1] == 7'h00; endproperty
    a_ist_rsv: assert property (p_ist_rsv) else $error("status reserved bit set");
    property p_lst_rsv; rd_lst |=> (io_rsp.data & 8'hd4) == 8'h00; endproperty
    a_lst_rsv: assert property (p_lst_rsv) else $error("line reserved bit set");
    // Both enables off leaves no source for the request
    property p_irq_off; wr_ctl && io_req.wdata[1:0] == 2'b00 ##1 !wr_ctl |=> !irq7; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq7 with enables off");
    c_lst_err: cover property (rd_lst ##1 io_rsp.data[3]);
    c_irq: cover property ($rose(irq7));
    c_thru: cover property (wr_ctl && io_req.wdata[4]);
endmodule // msp_chk

// file: dv/msp_midi_dev.sv
/* MIDI instrument: sends 8N1 frames, collects frames it hears.
 Assumes idle-high lines and the port's bit period. */
`timescale 1ns/100ps
module msp_midi_dev #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic  clk,
    input  wire logic  midi_out,
    output logic       midi_in = 1'b1,
    output logic [7:0] rx_byte,
    output int         rx_cnt
);
    // Trailing idle bit, so back-to-back frames never drive the line twice in one step
    task automatic send(input logic [7:0] b, input logic stop);
        logic [10:0] f;
        f = {1'b1, stop, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            midi_in <= f[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
    endtask
    initial begin
        rx_cnt = 0;
        forever begin
            @(negedge midi_out);
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                rx_byte[i] = midi_out;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            rx_cnt++;
        end
    end
endmodule // msp_midi_dev

// file: dv/tb_top.sv
/* Bench of the MIDI port: register sequences over the I/O strobes.
 Assumes the instrument model and a 200 MHz clock. */
`timescale 1ns/100ps
module tb_top import msp_pkg::*; ();
    localparam int BC = 8;
    logic        clk = 1'b0;
    logic        rst_b;
    msp_io_req_t io_req;
    msp_io_rsp_t io_rsp;
    logic        irq7, midi_in, midi_out;
    logic [7:0]  rx_byte;
    logic [7:0]  tx_b [3] = '{8'h5a, 8'h01, 8'hff};
    int          rx_cnt, n_mismatch = 0, tests_run = 0, cyc = 0;
    always #2.5 clk = ~clk;
    msp_port #(.BIT_CYCLES(BC)) DUT (.clk(clk), .rst_b(rst_b), .io_req(io_req), .io_rsp(io_rsp),
        .irq7(irq7), .midi_in(midi_in), .midi_out(midi_out));
    msp_midi_dev #(.BIT_CYCLES(BC)) u_dev (.clk(clk), .midi_out(midi_out), .midi_in(midi_in),
        .rx_byte(rx_byte), .rx_cnt(rx_cnt));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        io_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk);
        io_req <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
        io_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        io_req <= '0;
        #1;
        chk({nm, "_vld"}, 8'h01, {7'h00, io_rsp.valid});
        chk(nm, e, io_rsp.data);
        @(posedge clk);
    endtask
    task automatic wait_rx(input int n, input logic [7:0] e);
        for (int i = 0; i < 400 && rx_cnt < n; i++) @(posedge clk);
        chk("rx_byte", e, rx_byte);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Ceiling well above the roughly 1000 cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        rst_b  = 1'b0;
        io_req = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd("ctrl", MSP_CTRL_OFS, MSP_CTRL_RESET);
        rd("istat", MSP_ISTAT_OFS, 8'h00);
        rd("lstat", MSP_LSTAT_OFS, 8'h20);
        rd("unmapped", 10'h333, MSP_UNMAPPED_READ);
        wr(MSP_CTRL_OFS, 8'hff);
        rd("ctrl", MSP_CTRL_OFS, 8'h13);
        rd("istat_tx", MSP_ISTAT_OFS, 8'h01);
        chk("irq7", 8'h01, {7'h00, irq7});
        wr(MSP_ISTAT_OFS, 8'hff);
        wr(MSP_CTRL_OFS, 8'h01);
        rd("istat_rx", MSP_ISTAT_OFS, 8'h00);
        u_dev.send(8'ha5, 1'b1);
        rd("lstat_av", MSP_LSTAT_OFS, 8'h21);
        chk("irq7_rx", 8'h01, {7'h00, irq7});
        rd("data", MSP_DATA_OFS, 8'ha5);
        rd("istat_rd", MSP_ISTAT_OFS, 8'h00);
        u_dev.send(8'h3c, 1'b1);
        u_dev.send(8'hc3, 1'b0);
        rd("lstat_err", MSP_LSTAT_OFS, 8'h2b);
        rd("lstat_clr", MSP_LSTAT_OFS, 8'h21);
        rd("data_ovr", MSP_DATA_OFS, 8'hc3);
        wr(MSP_CTRL_OFS, 8'h00);
        foreach (tx_b[i]) wr(MSP_DATA_OFS, tx_b[i]);
        rd("lstat_full", MSP_LSTAT_OFS, 8'h00);
        wr(MSP_DATA_OFS, 8'hee);
        foreach (tx_b[i]) wait_rx(i + 1, tx_b[i]);
        repeat (40 * BC) @(posedge clk);
        chk("rx_cnt", 8'h03, rx_cnt[7:0]);
        wr(MSP_CTRL_OFS, 8'h10);
        u_dev.send(8'h96, 1'b1);
        wait_rx(4, 8'h96);
        rd("data_thru", MSP_DATA_OFS, 8'h96);
        tally_and_finish();
    end
endmodule // tb_top
bind msp_port msp_chk u_chk (.clk(clk), .rst_b(rst_b), .io_req(io_req), .io_rsp(io_rsp),
    .irq7(irq7), .midi_in(midi_in), .midi_out(midi_out));
